// [logic/actrg_regs.svh]
// actrg_regs.svh: register offsets, field positions and reset values
// for the acquisition trigger sequencer.
// assumes a 32-bit apb slave with byte addresses on aligned words.
`ifndef ACTRG_REGS_SVH
`define ACTRG_REGS_SVH

// register byte offsets
`define ACTRG_CTRL_OFFS      12'h000
`define ACTRG_FCOUNT_OFFS    12'h004
`define ACTRG_PERIOD_OFFS    12'h008
`define ACTRG_MINPER_OFFS    12'h00C
`define ACTRG_STATUS_OFFS    12'h010
`define ACTRG_FDONE_OFFS     12'h014

// control register fields
`define ACTRG_CTRL_ACQ_ON    0
`define ACTRG_CTRL_FRM_ON    1
`define ACTRG_CTRL_RATE_EN   2
`define ACTRG_CTRL_RUN       3

// reset values
`define ACTRG_CTRL_RST       32'h0000_0008
`define ACTRG_FCOUNT_RST     32'h0000_0003
`define ACTRG_PERIOD_RST     32'h0009_8968
`define ACTRG_MINPER_RST     32'h0000_0010

`endif

// [logic/actrg_pkg.sv]
// actrg_pkg.sv: types shared by the acquisition trigger sequencer.
// assumes the constants header is included by the design file.
package actrg_pkg;

  // acquisition status of the sequencer
  typedef enum logic [1:0] {
    ACTRG_IDLE,
    ACTRG_WAIT_ACQ,
    ACTRG_WAIT_FRM,
    ACTRG_EXPOSE
  } actrg_state_t;

  // software configuration travelling together
  typedef struct packed {
    logic        acq_on;    // external acquisition start path
    logic        frm_on;    // external frame start path
    logic        rate_en;   // frame rate setting enabled
    logic        run;       // acquisition running
    logic [31:0] fcount;    // frames per acquisition
    logic [31:0] period;    // frame period in clocks
    logic [31:0] minper;    // least period the settings allow
  } actrg_cfg_t;

endpackage : actrg_pkg

// [logic/actrg_seq.sv]
// actrg_seq.sv: acquisition trigger sequencer with apb registers.
// assumes an apb master on core_clk_in and an asynchronous trigger line.
//
// Function
// - both paths off: free run forever
// - internal frames at configured rate, slower if limited
// - rate disabled: run at maximum allowed rate
// - line rising edge is one frame trigger
// - acquisition path off: start generated internally
// - acquisition edge moves to wait-for-frame
// - after frame count, back to wait-for-acquisition
// - frame triggers ignored while awaiting acquisition
// - frame path off: triggers generated internally
// - frame triggers accepted only in wait-for-frame
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "actrg_regs.svh"

module actrg_seq
  import actrg_pkg::*;
#(
  parameter int EXPOSE_CYCLES = 4   // cycles one exposure holds the sequencer; one cycle when frm_on is set
) (
  input  wire logic        core_clk_in,     // 25 MHz core clock
  input  wire logic        rst_in,          // synchronous, active high
  input  wire logic        psel_in,         // apb select
  input  wire logic        penable_in,      // apb access phase
  input  wire logic        pwrite_in,       // apb direction
  input  wire logic [11:0] paddr_in,        // apb byte address
  input  wire logic [31:0] pwdata_in,       // apb write data
  output logic      [31:0] prdata_out,      // apb read data
  output logic             pready_out,      // apb ready
  output logic             pslverr_out,     // apb error on unmapped address
  input  wire logic        trig_line_in,    // input line 1, asynchronous
  output logic             frame_start_out, // one-cycle frame exposure start
  output logic             acq_wait_out,    // waiting for acquisition start
  output logic             frm_wait_out     // waiting for frame start
);

  // configuration and state registers
  actrg_cfg_t   cfg_reg;          // software settings
  actrg_state_t state_reg;        // acquisition status
  actrg_state_t state_next;       // next status
  logic [31:0]  frames_reg;       // frames taken in this burst
  logic [31:0]  frames_next;      // next frame count
  logic [31:0]  timer_reg;        // internal frame period timer
  logic [31:0]  timer_next;       // next timer value
  logic [31:0]  fdone_reg;        // total frames since reset
  logic [2:0]   line_sync_reg;    // two-stage synchroniser plus edge stage
  logic [31:0]  rdata_reg;        // registered read data
  logic         ready_reg;        // registered ready
  logic         err_reg;          // registered error
  logic         fstart_reg;       // registered frame start

  // control word after reset, split into fields by bit position below
  localparam logic [31:0] CTRL_RST_WORD = `ACTRG_CTRL_RST;

  // larger of two periods
  function automatic logic [31:0] max32(input logic [31:0] a, input logic [31:0] b);
    max32 = (a > b) ? a : b;
  endfunction

  // apb decode
  wire         apb_acc    = psel_in & penable_in & ~ready_reg;
  wire         apb_wr     = apb_acc & pwrite_in;
  wire         hit_ctrl   = (paddr_in == `ACTRG_CTRL_OFFS);
  wire         hit_fcount = (paddr_in == `ACTRG_FCOUNT_OFFS);
  wire         hit_period = (paddr_in == `ACTRG_PERIOD_OFFS);
  wire         hit_minper = (paddr_in == `ACTRG_MINPER_OFFS);
  wire         hit_status = (paddr_in == `ACTRG_STATUS_OFFS);
  wire         hit_fdone  = (paddr_in == `ACTRG_FDONE_OFFS);
  wire         hit_any    = hit_ctrl | hit_fcount | hit_period | hit_minper
                            | hit_status | hit_fdone;
  wire [31:0]  ctrl_word  = {28'h0000000, cfg_reg.run, cfg_reg.rate_en,
                             cfg_reg.frm_on, cfg_reg.acq_on};
  wire [31:0]  stat_word  = {28'h0000000, frames_reg[1:0] != 2'h0,
                             state_reg == ACTRG_EXPOSE, frm_wait_out, acq_wait_out};
  wire [31:0]  rd_mux     = hit_ctrl   ? ctrl_word :
                            hit_fcount ? cfg_reg.fcount :
                            hit_period ? cfg_reg.period :
                            hit_minper ? cfg_reg.minper :
                            hit_status ? stat_word :
                            hit_fdone  ? fdone_reg : 32'h00000000;

  // trigger line edge, read only after two flip-flops
  // rising edge detect
  wire line_rise = line_sync_reg[1] & ~line_sync_reg[2];

  wire [31:0] eff_period = cfg_reg.rate_en ? max32(cfg_reg.period, cfg_reg.minper)
                                           : cfg_reg.minper;
  wire        timer_due  = (timer_reg >= eff_period - 32'h00000001);

  wire frm_trig = cfg_reg.frm_on ? line_rise : timer_due;
  wire acq_trig = cfg_reg.acq_on ? line_rise : 1'b1;

  // next-state logic of the sequencer
  always_comb begin
    state_next  = state_reg;
    frames_next = frames_reg;
    timer_next  = timer_due ? 32'h00000000 : timer_reg + 32'h00000001;
    case (state_reg)
      ACTRG_IDLE: begin
        if (cfg_reg.run) begin
          state_next = ACTRG_WAIT_ACQ;
        end
      end
      ACTRG_WAIT_ACQ: begin
        if (!cfg_reg.run) begin
          state_next = ACTRG_IDLE;
        end else if (acq_trig) begin
          state_next  = ACTRG_WAIT_FRM;
          frames_next = 32'h00000000;
          timer_next  = 32'h00000000;
        end
      end
      ACTRG_WAIT_FRM: begin
        if (!cfg_reg.run) begin
          state_next = ACTRG_IDLE;
        end else if (frm_trig) begin
          state_next  = ACTRG_EXPOSE;
          frames_next = frames_reg + 32'h00000001;
        end
      end
      default: begin
        // exposure in progress: triggers discarded
        if (timer_reg >= EXPOSE_CYCLES - 1 || cfg_reg.frm_on) begin
          state_next = (frames_reg >= cfg_reg.fcount) ? ACTRG_WAIT_ACQ : ACTRG_WAIT_FRM;
        end
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_reg     <= ACTRG_IDLE;
      frames_reg    <= 32'h00000000;
      timer_reg     <= 32'h00000000;
      fdone_reg     <= 32'h00000000;
      line_sync_reg <= 3'h0;
      fstart_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      frames_reg    <= frames_next;
      timer_reg     <= timer_next;
      line_sync_reg <= {line_sync_reg[1:0], trig_line_in};
      fstart_reg    <= (state_reg == ACTRG_WAIT_FRM) & cfg_reg.run & frm_trig;
      fdone_reg     <= fdone_reg + {31'h00000000, fstart_reg};
    end
  end

  // apb slave: one wait state, writes take effect at the answering edge
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      // fields by name: a packed copy would put the run bit in the wrong slot
      cfg_reg.acq_on  <= CTRL_RST_WORD[`ACTRG_CTRL_ACQ_ON];
      cfg_reg.frm_on  <= CTRL_RST_WORD[`ACTRG_CTRL_FRM_ON];
      cfg_reg.rate_en <= CTRL_RST_WORD[`ACTRG_CTRL_RATE_EN];
      cfg_reg.run     <= CTRL_RST_WORD[`ACTRG_CTRL_RUN];
      cfg_reg.fcount  <= `ACTRG_FCOUNT_RST;
      cfg_reg.period  <= `ACTRG_PERIOD_RST;
      cfg_reg.minper  <= `ACTRG_MINPER_RST;
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ready_reg <= apb_acc;
      err_reg   <= apb_acc & ~hit_any;
      rdata_reg <= (apb_acc & ~pwrite_in) ? rd_mux : 32'h00000000;
      if (apb_wr & hit_ctrl) begin
        cfg_reg.acq_on  <= pwdata_in[`ACTRG_CTRL_ACQ_ON];
        cfg_reg.frm_on  <= pwdata_in[`ACTRG_CTRL_FRM_ON];
        cfg_reg.rate_en <= pwdata_in[`ACTRG_CTRL_RATE_EN];
        cfg_reg.run     <= pwdata_in[`ACTRG_CTRL_RUN];
      end
      if (apb_wr & hit_fcount) begin
        // a zero count is treated as one frame
        cfg_reg.fcount <= max32(pwdata_in, 32'h00000001);
      end
      if (apb_wr & hit_period) begin
        cfg_reg.period <= max32(pwdata_in, 32'h00000001);
      end
      if (apb_wr & hit_minper) begin
        cfg_reg.minper <= max32(pwdata_in, 32'h00000001);
      end
    end
  end

  // outputs straight from flip-flops
  always_comb begin
    prdata_out      = rdata_reg;
    pready_out      = ready_reg;
    pslverr_out     = err_reg;
    frame_start_out = fstart_reg;
  end

  // status outputs registered separately
  logic acq_wait_reg;  // registered wait-for-acquisition
  logic frm_wait_reg;  // registered wait-for-frame
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      acq_wait_reg <= 1'b0;
      frm_wait_reg <= 1'b0;
    end else begin
      acq_wait_reg <= (state_next == ACTRG_WAIT_ACQ);
      frm_wait_reg <= (state_next == ACTRG_WAIT_FRM);
    end
  end
  assign acq_wait_out = acq_wait_reg;
  assign frm_wait_out = frm_wait_reg;

endmodule // actrg_seq

// [tb/actrg_seq_props.sv]
// actrg_seq_props.sv: port-level assertions for the trigger sequencer.
// assumes it is bound to actrg_seq and sees only that module's ports.
`timescale 1ns/100ps
module actrg_seq_props (
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [31:0] prdata_out,
  input wire logic        frame_start_out,
  input wire logic        acq_wait_out,
  input wire logic        frm_wait_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // access phase still waiting, then a single-cycle answer
  sequence s_acc; psel_in && penable_in && !pready_out; endsequence
  sequence s_ans; pready_out ##1 !pready_out; endsequence
  AST_APB_ANSWER: assert property (s_acc |=> s_ans)
    else $error("apb answer not one cycle after access");
  AST_ERR_QUAL: assert property (pslverr_out |-> pready_out)
    else $error("error flag without ready");
  AST_RDATA_IDLE: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  AST_WAIT_EXCL: assert property (!(acq_wait_out && frm_wait_out))
    else $error("both wait states at once");
  AST_ACQ_TO_FRM: assert property ($fell(acq_wait_out) |-> frm_wait_out)
    else $error("left acquisition wait elsewhere");
  // exposure may only start from the frame wait, never from acquisition wait
  AST_NO_FRM_IN_ACQ: assert property (frame_start_out |-> !$past(acq_wait_out))
    else $error("frame while awaiting acquisition");
  AST_FRM_FROM_WAIT: assert property (frame_start_out |-> $past(frm_wait_out))
    else $error("frame not from frame wait");
  AST_FRM_PULSE: assert property (frame_start_out |=> !frame_start_out)
    else $error("frame start wider than one cycle");
endmodule // actrg_seq_props

// [tb/actrg_trig_src.sv]
// actrg_trig_src.sv: external trigger source driving input line 1.
// assumes the bench calls pulse; the line idles low between pulses.
`timescale 1ns/100ps
module actrg_trig_src (
  input  wire logic clk_in,
  output logic      line_out
);
  initial line_out = 1'b0;
  // one rising edge per wanted trigger, hold sets the pace
  task automatic pulse(input int hold);
    @(posedge clk_in);
    line_out <= 1'b1;
    repeat (hold) @(posedge clk_in);
    line_out <= 1'b0;
    repeat (hold) @(posedge clk_in);
  endtask
endmodule // actrg_trig_src

// [tb/actrg_tb_top.sv]
// actrg_tb_top.sv: self-checking bench for the trigger sequencer.
// assumes package, header, checker and trigger source are compiled first.
`timescale 1ns/100ps
`include "actrg_regs.svh"
module actrg_tb_top;
  logic        core_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out, rd;
  logic        pready_out, pslverr_out, err, line, frame_start_out, acq_wait_out, frm_wait_out;
  int          fail_count = 0, checks = 0, cyc = 0, nfr = 0, last = 0, gap = 0, base;
  logic [11:0] ra [4] = '{`ACTRG_CTRL_OFFS, `ACTRG_FCOUNT_OFFS, `ACTRG_PERIOD_OFFS,
                          `ACTRG_MINPER_OFFS};
  logic [31:0] rv [4] = '{`ACTRG_CTRL_RST, `ACTRG_FCOUNT_RST, `ACTRG_PERIOD_RST, `ACTRG_MINPER_RST};
  always #20 core_clk_in = ~core_clk_in;
  actrg_seq uut (.core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .trig_line_in(line), .frame_start_out(frame_start_out),
    .acq_wait_out(acq_wait_out), .frm_wait_out(frm_wait_out));
  actrg_trig_src src (.clk_in(core_clk_in), .line_out(line));
  // frame count and spacing of the last two frames, in clocks
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (frame_start_out === 1'b1) begin
      nfr <= nfr + 1;
      gap <= cyc - last;
      last <= cyc;
    end
  end
  // hang guard: the whole run needs under a thousand cycles
  always @(posedge core_clk_in) if (cyc == 20000) begin
    fail_count++;
    results();
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do @(posedge core_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wf(input int n);
    int b;
    b = nfr;
    while (nfr < b + n) @(posedge core_clk_in);
  endtask
  task automatic results();
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", rd, rv[i]);
    end
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    // long bursts so spacing is measured inside one burst
    apb(1'b1, `ACTRG_FCOUNT_OFFS, 32'h0000_0100);
    wf(3);
    chk("free run gap", gap, `ACTRG_MINPER_RST);
    apb(1'b1, `ACTRG_PERIOD_OFFS, 32'h0000_0028);
    apb(1'b1, `ACTRG_CTRL_OFFS, 32'h0000_000C);
    wf(3);
    chk("rate gap", gap, 32'h0000_0028);
    apb(1'b1, `ACTRG_PERIOD_OFFS, 32'h0000_0008);
    wf(3);
    chk("limited gap", gap, `ACTRG_MINPER_RST);
    apb(1'b0, `ACTRG_PERIOD_OFFS, 32'h0);
    chk("period readback", rd, 32'h0000_0008);
    apb(1'b1, `ACTRG_FCOUNT_OFFS, 32'h0000_0003);
    apb(1'b1, `ACTRG_CTRL_OFFS, 32'h0000_0009);
    while (acq_wait_out !== 1'b1) @(posedge core_clk_in);
    base = nfr;
    repeat (60) @(posedge core_clk_in);
    chk("idle frames", nfr - base, 32'h0);
    // two bursts: the per-burst frame count must restart each time
    repeat (2) begin
      base = nfr;
      src.pulse(4);
      chk("left acq wait", {31'h0, acq_wait_out}, 32'h0);
      wf(3);
      repeat (60) @(posedge core_clk_in);
      chk("burst frames", nfr - base, 32'h3);
      chk("rearmed wait", {31'h0, acq_wait_out}, 32'h1);
    end
    // status: waiting for acquisition, burst count still nonzero
    apb(1'b0, `ACTRG_STATUS_OFFS, 32'h0);
    chk("burst status", rd, 32'h0000_0009);
    apb(1'b1, `ACTRG_CTRL_OFFS, 32'h0000_000A);
    while (frm_wait_out !== 1'b1) @(posedge core_clk_in);
    base = nfr;
    repeat (4) src.pulse(4);
    repeat (10) @(posedge core_clk_in);
    chk("line frames", nfr - base, 32'h4);
    apb(1'b0, `ACTRG_FDONE_OFFS, 32'h0);
    chk("frame total", rd, nfr);
    results();
  end
endmodule // actrg_tb_top
bind actrg_seq actrg_seq_props u_props (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .prdata_out(prdata_out), .frame_start_out(frame_start_out),
  .acq_wait_out(acq_wait_out), .frm_wait_out(frm_wait_out));
